// File: src/sdram_device.sv
// SDRAM device end: mode register, burst sequencing, read latency
// What the document requires of controller and device
// RULE1: Controller waits 100 us before real commands
// RULE2: Controller sends inhibit or nop during wait
// RULE3: Clock gate low, raised during the wait
// RULE4: Precharge all, then idle for recovery
// RULE5: At least two refreshes, each with wait
// RULE6: Refreshes may follow mode load, repeat
// RULE7: Mode register loaded before use, then kept
// RULE8: Mode load uses both bank selects zero
// RULE9: Data outputs high-impedance after mode load
// RULE10: Wait mode load delay with nops only
// RULE11: Mode load only with all banks idle
// RULE12: Mode register field layout
// RULE13: Latency codes two and three only
// RULE14: Spans 1,2,4,8; full page sequential
// RULE15: Full page wraps in row, terminate ends
// RULE16: Burst stays inside aligned block, wraps
// RULE17: Sequential adds, interleaved xors offset
// RULE18: Span one ignores order bit
// RULE19: Drive from n+m-1, valid at n+m
// RULE20: Controller never programs reserved spans
// RULE21: Operating mode bits must be zero
// RULE22: Write burst bit makes writes single
// RULE23: Order bit zero sequential, one interleaved
`timescale 1ns/1ps
`include "sdram_init_regs.svh"
module sdram_device
  import sdram_init_pkg::*;
(
  input  wire logic  clk,            // Link clock
  input  wire logic  reset,          // Synchronous reset, active high
  sdram_link_if.dev  link,           // Pins from the controller
  output logic [11:0] mode_value,    // Stored mode register
  output logic        mode_loaded,   // Mode register has been loaded
  output logic        read_strobe,   // Read of one column this cycle
  output logic        write_strobe,  // Write of one column this cycle
  output col_t        column,        // Column being accessed
  output data_t       write_data,    // Data written this cycle
  input  data_t       read_data      // Array data for read column
);

  // ----------------------------------------------------------------
  // Burst address arithmetic
  // ----------------------------------------------------------------
  // Offset mask for the programmed span; zero for span one
  function automatic col_t span_mask(input logic [2:0] code);
    case (code)
      `SPAN_CODE_2:    span_mask = 8'h01;
      `SPAN_CODE_4:    span_mask = 8'h03;
      `SPAN_CODE_8:    span_mask = 8'h07;
      `SPAN_CODE_PAGE: span_mask = 8'hff;
      default:         span_mask = 8'h00;
    endcase
  endfunction : span_mask

  function automatic col_t burst_col(input col_t start, input col_t idx, input col_t mask,
                                     input logic interleave);
    col_t off;
    off = interleave ? ((start ^ idx) & mask) : ((start + idx) & mask); // RULE17 RULE23
    burst_col = (start & ~mask) | off;                                 // RULE16 RULE15
  endfunction : burst_col

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  logic [11:0] mode_q;
  logic        loaded_q;
  logic        load_cmd;
  logic        clk_gate_s1_q;
  logic        clk_gate_q;

  // Clock gate comes from the pins and is synchronised before use
  always_ff @(posedge clk)
  begin
    clk_gate_s1_q <= link.clk_gate;
    clk_gate_q    <= clk_gate_s1_q;
  end

  assign load_cmd = clk_gate_q && link.cmd == `CMD_LOAD_MODE;

  // Unknown value at power-up is modelled as zero plus a not-loaded flag
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_q   <= 12'h000;
      loaded_q <= 1'b0;
    end
    else if (load_cmd && !link.bank_select_low && !link.bank_select_high) // RULE8
    begin
      mode_q   <= link.addr;  // RULE7 RULE12
      loaded_q <= 1'b1;
    end
  end

  logic [2:0] span_code;
  logic       order_bit;
  logic [2:0] lat_code;
  logic       write_single;
  logic       normal_mode;
  col_t       mask_w;
  logic [2:0] lat_cycles;

  assign span_code    = mode_q[`MODE_SPAN_MSB:`MODE_SPAN_LSB];
  assign lat_code     = mode_q[`MODE_LAT_MSB:`MODE_LAT_LSB];
  assign write_single = mode_q[`MODE_WRITE_BURST_BIT];
  assign normal_mode  = !mode_q[`MODE_OPM_LOW_BIT] && !mode_q[`MODE_OPM_HIGH_BIT]; // RULE21
  // Full page with interleaving is unsupported; fall back to sequential
  assign order_bit    = mode_q[`MODE_ORDER_BIT] && span_code != `SPAN_CODE_PAGE; // RULE14
  assign mask_w       = span_mask(span_code);                                      // RULE18
  // Reserved latency codes behave as three to keep data on the bus defined
  assign lat_cycles   = (lat_code == `LAT_CODE_2) ? 3'h2 : 3'h3;                   // RULE13

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  typedef enum {IDLE, READING, WRITING} burst_state_t;
  burst_state_t state_q;
  col_t start_q;
  col_t idx_q;
  col_t len_m1_q;
  logic order_q;
  col_t mask_q;
  logic issue_ok;

  assign issue_ok = clk_gate_q && loaded_q && normal_mode;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q  <= IDLE;
      start_q  <= 8'h00;
      idx_q    <= 8'h00;
      len_m1_q <= 8'h00;
      order_q  <= 1'b0;
      mask_q   <= 8'h00;
    end
    else if (issue_ok && (link.cmd == `CMD_READ || link.cmd == `CMD_WRITE))
    begin
      state_q  <= (link.cmd == `CMD_READ) ? READING : WRITING;
      start_q  <= link.addr[7:0];
      idx_q    <= 8'h00;
      order_q  <= order_bit;
      // Single-location writes when the write burst bit is set
      mask_q   <= (link.cmd == `CMD_WRITE && write_single) ? 8'h00 : mask_w; // RULE22
      len_m1_q <= (link.cmd == `CMD_WRITE && write_single) ? 8'h00 : mask_w;
    end
    // A mode load ends any burst so the data pins stay released after it
    else if (load_cmd)
      state_q <= IDLE;                                                     // RULE9
    else if (issue_ok && (link.cmd == `CMD_TERMINATE || link.cmd == `CMD_PRECHARGE))
      state_q <= IDLE;                                                     // RULE15
    else
    begin
      case (state_q)
        READING, WRITING:
        begin
          // Full page never ends by itself; it wraps until terminated
          if (idx_q == len_m1_q && mask_q != 8'hff)
            state_q <= IDLE;
          idx_q <= idx_q + 8'h01;
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  col_t cur_col;
  assign cur_col = burst_col(start_q, idx_q, mask_q, order_q);

  // Write data is taken in the same cycle as each write column
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      write_strobe <= 1'b0;
      write_data   <= 16'h0000;
    end
    else
    begin
      write_strobe <= (state_q == WRITING);
      write_data   <= link.dq_from_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Read latency pipeline
  // ----------------------------------------------------------------
  // Array fetch happens at burst index time; delay line adds the rest
  logic       rd_pipe_q;
  logic       rd_now;
  assign rd_now = (state_q == READING);

  always_ff @(posedge clk)
  begin
    if (reset || load_cmd)
      rd_pipe_q <= 1'b0;  // RULE9
    else
      rd_pipe_q <= rd_now;
  end

  // Command at edge n, burst index starts n+1; drive from n+m-1
  logic drive_w;
  col_t col_d1_q;
  assign drive_w = (lat_cycles == 3'h2) ? rd_now : rd_pipe_q; // RULE19

  always_ff @(posedge clk)
  begin
    if (reset || load_cmd)
    begin
      link.dq_oe_dev  <= 1'b0; // RULE9
      link.dq_from_dev <= 16'h0000;
    end
    else
    begin
      link.dq_oe_dev  <= drive_w;
      link.dq_from_dev <= read_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      read_strobe <= 1'b0;
      column      <= 8'h00;
      col_d1_q    <= 8'h00;
    end
    else
    begin
      read_strobe <= drive_w;
      col_d1_q    <= cur_col;
      // Latency three reads lag the burst index by one stage
      column      <= (drive_w && lat_cycles != 3'h2) ? col_d1_q : cur_col; // RULE19
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_value  <= 12'h000;
      mode_loaded <= 1'b0;
    end
    else
    begin
      mode_value  <= mode_q;
      mode_loaded <= loaded_q;
    end
  end

endmodule : sdram_device

// File: src/sdram_init_regs.svh
// Constants for the SDRAM mode register, commands and init timing
`ifndef SDRAM_INIT_REGS_SVH
`define SDRAM_INIT_REGS_SVH

// Mode register fields
`define MODE_SPAN_LSB        0
`define MODE_SPAN_MSB        2
`define MODE_ORDER_BIT       3
`define MODE_LAT_LSB         4
`define MODE_LAT_MSB         6
`define MODE_OPM_LOW_BIT     7
`define MODE_OPM_HIGH_BIT    8
`define MODE_WRITE_BURST_BIT 9

// Burst length codes
`define SPAN_CODE_1          3'h0
`define SPAN_CODE_2          3'h1
`define SPAN_CODE_4          3'h2
`define SPAN_CODE_8          3'h3
`define SPAN_CODE_PAGE       3'h7

// Read latency codes
`define LAT_CODE_2           3'h2
`define LAT_CODE_3           3'h3

// Command encodings {cs_n, ras_n, cas_n, we_n}
`define CMD_INHIBIT          4'h8
`define CMD_NOP              4'h7
`define CMD_ACTIVE           4'h3
`define CMD_READ             4'h5
`define CMD_WRITE            4'h4
`define CMD_TERMINATE        4'h6
`define CMD_PRECHARGE        4'h2
`define CMD_REFRESH          4'h1
`define CMD_LOAD_MODE        4'h0

// Precharge-all address bit
`define ADDR_ALL_BANKS_BIT   10

// Timing at 40 MHz (25 ns clock)
`define CLK_PERIOD_NS        25
`define POWERUP_WAIT_US      100
`define POWERUP_WAIT_CYC     ((`POWERUP_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define PRECHARGE_REC_NS     20
`define PRECHARGE_REC_CYC    ((`PRECHARGE_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CYC_NS       66
`define REFRESH_CYC_CYC      ((`REFRESH_CYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_LOAD_DELAY_CYC  2
`define INIT_REFRESH_COUNT   2
`define GATE_RAISE_CYC       16
`define PAGE_COLUMNS         256

`endif

// File: src/sdram_init_pkg.sv
// Types shared by both ends of the SDRAM link
package sdram_init_pkg;
  typedef logic [3:0]  cmd_t;
  typedef logic [11:0] addr_t;
  typedef logic [15:0] data_t;
  typedef logic [7:0]  col_t;
endpackage : sdram_init_pkg

// File: src/sdram_link_if.sv
// Pin-level link between memory controller and SDRAM device
`timescale 1ns/1ps
interface sdram_link_if;
  import sdram_init_pkg::*;
  logic        clk_gate;
  cmd_t        cmd;
  logic        bank_select_low;
  logic        bank_select_high;
  addr_t       addr;
  data_t       dq_from_ctrl;
  logic        dq_oe_ctrl;
  data_t       dq_from_dev;
  logic        dq_oe_dev;
  data_t       dq;

  assign dq = dq_oe_dev ? dq_from_dev : (dq_oe_ctrl ? dq_from_ctrl : '0);

  modport ctrl (
    output clk_gate, cmd, bank_select_low, bank_select_high, addr, dq_from_ctrl, dq_oe_ctrl,
    input  dq
  );
  modport dev (
    input  clk_gate, cmd, bank_select_low, bank_select_high, addr, dq_from_ctrl, dq_oe_ctrl,
    output dq_from_dev, dq_oe_dev
  );
endinterface : sdram_link_if

// File: src/sdram_controller.sv
// Memory controller end: power-up sequence and mode register load
`timescale 1ns/1ps
`include "sdram_init_regs.svh"
module sdram_controller
  import sdram_init_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = `POWERUP_WAIT_CYC  // Power-up wait
)(
  input  wire logic  clk,          // Link clock
  input  wire logic  reset,        // Synchronous reset, active high
  input  addr_t      mode_setting, // Value for the mode register
  sdram_link_if.ctrl link,         // Pins to the device
  output logic       init_done     // Device ready for any command
);

  typedef enum {WAIT_PWR, PRECHARGE, WAIT_RP, REFRESH, WAIT_RFC,
                LOAD, WAIT_MRD, DONE} init_state_t;
  init_state_t state_q;
  logic [15:0] cnt_q;
  logic [3:0]  ref_q;

  // ----------------------------------------------------------------
  // Init sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= WAIT_PWR;
      cnt_q   <= 16'h0000;
      ref_q   <= 4'h0;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        WAIT_PWR:
          if (cnt_q == 16'(POWERUP_CYC - 1))                       // RULE1
            state_q <= PRECHARGE;
        PRECHARGE:
        begin
          state_q <= WAIT_RP;
          cnt_q   <= 16'h0000;
        end
        WAIT_RP:
          if (cnt_q == 16'(`PRECHARGE_REC_CYC - 1))                // RULE4
            state_q <= REFRESH;
        REFRESH:
        begin
          state_q <= WAIT_RFC;
          cnt_q   <= 16'h0000;
          ref_q   <= ref_q + 4'h1;
        end
        WAIT_RFC:
          if (cnt_q == 16'(`REFRESH_CYC_CYC - 1))                  // RULE5
            state_q <= (ref_q == 4'(`INIT_REFRESH_COUNT)) ? LOAD : REFRESH; // RULE6
        LOAD:
        begin
          state_q <= WAIT_MRD;
          cnt_q   <= 16'h0000;
        end
        WAIT_MRD:
          if (cnt_q == 16'(`MODE_LOAD_DELAY_CYC - 1))              // RULE10
            state_q <= DONE;
        default: state_q <= DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      link.clk_gate <= 1'b0;                                       // RULE3
      link.cmd      <= `CMD_INHIBIT;
      link.addr     <= 12'h000;
      link.bank_select_low  <= 1'b0;
      link.bank_select_high <= 1'b0;
      link.dq_from_ctrl     <= 16'h0000;
      link.dq_oe_ctrl       <= 1'b0;
      init_done     <= 1'b0;
    end
    else
    begin
      if (state_q == WAIT_PWR && cnt_q == 16'(`GATE_RAISE_CYC))
        link.clk_gate <= 1'b1;                                     // RULE3
      link.addr <= 12'h000;
      link.bank_select_low  <= 1'b0;
      link.bank_select_high <= 1'b0;
      case (state_q)
        WAIT_PWR: link.cmd <= `CMD_NOP;                             // RULE2
        PRECHARGE:
        begin
          link.cmd <= `CMD_PRECHARGE;                              // RULE4 RULE11
          link.addr[`ADDR_ALL_BANKS_BIT] <= 1'b1;
        end
        REFRESH:  link.cmd <= `CMD_REFRESH;                         // RULE5
        LOAD:
        begin
          link.cmd  <= `CMD_LOAD_MODE;                             // RULE7 RULE8
          // Reserved spans and test modes would be unspecified
          link.addr <= mode_setting;                               // RULE20 RULE21
        end
        DONE:     link.cmd <= `CMD_NOP;
        default:  link.cmd <= `CMD_NOP;
      endcase
      init_done <= (state_q == DONE);
    end
  end

endmodule : sdram_controller

// File: tb/sdram_init_and_mode_setup_monitor.sv
// Checker for the controller-to-device link during power-up
`timescale 1ns/1ps
`include "sdram_init_regs.svh"
module sdram_init_and_mode_setup_monitor
  import sdram_init_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = `POWERUP_WAIT_CYC  // Power-up wait in cycles
)(
  input wire logic  clk,              // Link clock
  input wire logic  reset,            // Synchronous reset
  input wire logic  clk_gate,         // Clock gate
  input wire cmd_t  cmd,              // Command code
  input wire logic  bank_select_low,  // Bank select low
  input wire logic  bank_select_high, // Bank select high
  input wire addr_t addr,             // Address
  input wire logic  dq_oe_dev         // Device drives data
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic [15:0] cyc_q;
  logic [3:0]  n_ref_q;
  logic        pre_q;

  always_ff @(posedge clk)
    if (reset) cyc_q <= '0;
    else if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h1;

  always_ff @(posedge clk)
    if (reset) n_ref_q <= '0;
    else if (cmd == `CMD_REFRESH && n_ref_q != 4'hf) n_ref_q <= n_ref_q + 4'h1;

  always_ff @(posedge clk)
    if (reset) pre_q <= 1'b0;
    else if (cmd == `CMD_PRECHARGE) pre_q <= 1'b1;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Inhibit has chip select high; nop is the one selected idle code
  sequence s_idle;
    cmd == `CMD_NOP || cmd[3];
  endsequence
  sequence s_quiet;
    (cmd == `CMD_NOP || cmd[3]) && !dq_oe_dev;
  endsequence

  property p_gate_low;
    $fell(reset) |-> !clk_gate;
  endproperty
  property p_wait;
    (cyc_q < POWERUP_CYC) |-> s_idle;
  endproperty
  property p_gate_early;
    (cyc_q == POWERUP_CYC) |-> clk_gate;
  endproperty
  property p_pre_all;
    cmd == `CMD_PRECHARGE |-> addr[`ADDR_ALL_BANKS_BIT] ##1 s_idle;
  endproperty
  property p_refresh;
    cmd == `CMD_REFRESH |-> pre_q ##1 s_idle [*2];
  endproperty
  property p_ref_count;
    cmd == `CMD_LOAD_MODE |-> n_ref_q >= 4'h2;
  endproperty
  property p_load_banks;
    cmd == `CMD_LOAD_MODE |-> !bank_select_low && !bank_select_high;
  endproperty
  property p_load_wait;
    cmd == `CMD_LOAD_MODE |=> s_quiet;
  endproperty

  a_gate_low:   assert property (p_gate_low) else $error("clock gate high after reset");
  a_wait:       assert property (p_wait) else $error("command inside power-up wait");
  a_gate_early: assert property (p_gate_early) else $error("clock gate not raised");
  a_pre_all:    assert property (p_pre_all) else $error("bad precharge");
  a_refresh:    assert property (p_refresh) else $error("bad refresh spacing");
  a_ref_count:  assert property (p_ref_count) else $error("too few refreshes");
  a_load_banks: assert property (p_load_banks) else $error("mode load bank nonzero");
  a_load_wait:  assert property (p_load_wait) else $error("activity after mode load");
endmodule : sdram_init_and_mode_setup_monitor

// File: tb/test_sdram_init_and_mode_setup.sv
// Self-checking bench for SDRAM power-up and mode register
`timescale 1ns/1ps
`include "sdram_init_regs.svh"
module test_sdram_init_and_mode_setup;
  import sdram_init_pkg::*;
  localparam int unsigned PUP = 40;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  addr_t       mode_setting;
  logic        init_done, loaded_a, loaded_b, rd_b, wr_b;
  logic [11:0] mval_a, mval_b;
  col_t        col_b;
  data_t       rdata_b, wdata_b;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_ref = 0;
  logic [31:0] seed = 32'h9cc9;
  col_t        got[$];

  sdram_link_if link_a ();
  sdram_link_if link_b ();
  always #12.5 clk = ~clk;

  sdram_controller #(.POWERUP_CYC(PUP)) i_sdram_controller (.clk(clk), .reset(reset),
    .mode_setting(mode_setting), .link(link_a.ctrl), .init_done(init_done));
  sdram_device i_sdram_device (.clk(clk), .reset(reset), .link(link_a.dev),
    .mode_value(mval_a), .mode_loaded(loaded_a), .read_strobe(), .write_strobe(),
    .column(), .write_data(), .read_data(16'h0000));
  // Second device is driven straight by the bench to reach the burst logic
  sdram_device i_sdram_device_b (.clk(clk), .reset(reset), .link(link_b.dev),
    .mode_value(mval_b), .mode_loaded(loaded_b), .read_strobe(rd_b), .write_strobe(wr_b),
    .column(col_b), .write_data(wdata_b), .read_data(rdata_b));
  sdram_init_and_mode_setup_monitor #(.POWERUP_CYC(PUP)) i_monitor (.clk(clk),
    .reset(reset), .clk_gate(link_a.clk_gate), .cmd(link_a.cmd),
    .bank_select_low(link_a.bank_select_low), .bank_select_high(link_a.bank_select_high),
    .addr(link_a.addr), .dq_oe_dev(link_a.dq_oe_dev));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic col_t ecol(col_t st, int len, logic ord, int i);
    col_t msk = col_t'(len - 1);
    col_t off = ord ? (st ^ col_t'(i)) : (st + col_t'(i));
    return (st & ~msk) | (off & msk);
  endfunction : ecol

  always @(negedge clk) rdata_b <= 16'(rnd());
  always @(posedge clk) if (!reset && link_a.cmd == `CMD_REFRESH) n_ref++;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic cmd_b(input cmd_t c, input addr_t a, input logic bh);
    @(negedge clk);
    link_b.cmd = c;
    link_b.addr = a;
    link_b.bank_select_high = bh;
    @(negedge clk);
    link_b.cmd = `CMD_NOP;
    link_b.bank_select_high = 1'b0;
  endtask : cmd_b

  // Load a mode, start one burst and compare the column walk with the model
  task automatic run(input logic [2:0] sc, input logic ord, input logic [2:0] lat,
                     input logic [1:0] opm, input col_t st, input logic wr, input logic wb);
    addr_t m;
    int    len;
    int    n;
    int    first;
    data_t prev_w;
    m = {2'b00, wb, opm, lat, ord, sc};
    len = (sc == `SPAN_CODE_PAGE) ? `PAGE_COLUMNS : (1 << sc);
    n = (opm != 2'b00) ? 0 : (wr && wb) ? 1 : len;
    first = 0;
    got.delete();
    cmd_b(`CMD_LOAD_MODE, m, 1'b0);
    @(negedge clk);
    chk(mval_b, m);
    cmd_b(`CMD_ACTIVE, 12'h000, 1'b0);
    @(negedge clk);
    link_b.cmd = wr ? `CMD_WRITE : `CMD_READ;
    link_b.addr = {4'h0, st};
    link_b.dq_oe_ctrl = wr;
    for (int c = 1; c <= 40; c++)
    begin
      @(negedge clk);
      if (c == 1 || c == 9) link_b.cmd = `CMD_NOP;
      if (c == 8 && len == `PAGE_COLUMNS) link_b.cmd = `CMD_TERMINATE;
      prev_w = link_b.dq_from_ctrl;
      link_b.dq_from_ctrl = 16'(rnd());
      if (first == 0 && link_b.dq_oe_dev === 1'b1) first = c;
      if (link_b.dq_oe_dev === 1'b1) chk(link_b.dq, rdata_b);
      if (wr_b === 1'b1) chk(wdata_b, prev_w);
      if ((wr ? wr_b : rd_b) === 1'b1) got.push_back(col_b);
    end
    link_b.dq_oe_ctrl = 1'b0;
    if (len == `PAGE_COLUMNS) chk(got.size() inside {[4:255]}, 1);
    else chk(got.size(), n);
    foreach (got[i]) chk(got[i], ecol(st, len, ord, i));
    if (!wr && n > 0) chk(first, lat);
  endtask : run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    link_b.clk_gate = 1'b0;
    link_b.cmd = `CMD_INHIBIT;
    link_b.bank_select_low = 1'b0;
    link_b.bank_select_high = 1'b0;
    link_b.addr = '0;
    link_b.dq_from_ctrl = '0;
    link_b.dq_oe_ctrl = 1'b0;
    mode_setting = {5'h00, `LAT_CODE_3, 1'b1, `SPAN_CODE_8};
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(loaded_a, 0);
    link_b.clk_gate = 1'b1;
    repeat (4) @(negedge clk);
    cmd_b(`CMD_READ, 12'h005, 1'b0);
    repeat (8) @(negedge clk) if (rd_b === 1'b1) got.push_back(col_b);
    chk(got.size(), 0);
    cmd_b(`CMD_LOAD_MODE, 12'h023, 1'b1);
    @(negedge clk);
    chk(loaded_b, 0);
    for (int s = 0; s < 4; s++)
      for (int o = 0; o < 2; o++)
        run(3'(s), 1'(o), o ? `LAT_CODE_3 : `LAT_CODE_2, 2'b00, col_t'(rnd()), 0, 0);
    run(`SPAN_CODE_PAGE, 0, `LAT_CODE_3, 2'b00, 8'hfc, 0, 0);
    run(`SPAN_CODE_4, 1, `LAT_CODE_2, 2'b01, col_t'(rnd()), 0, 0);
    run(`SPAN_CODE_8, 0, `LAT_CODE_3, 2'b00, col_t'(rnd()), 1, 1);
    run(`SPAN_CODE_4, 1, `LAT_CODE_2, 2'b00, col_t'(rnd()), 1, 0);
    for (int k = 0; k < 3000 && init_done !== 1'b1; k++) @(negedge clk);
    if (init_done !== 1'b1)
      n_fail++;
    else
    begin
      chk(mval_a, mode_setting);
      chk(loaded_a, 1);
      chk(n_ref >= 2, 1);
    end
    wrap_up();
  end
endmodule : test_sdram_init_and_mode_setup
